//--- core/gpio_port_pkg.sv
package gpio_port_pkg;
  localparam int PIN_W = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int STRB_W = DATA_W / 8;
  localparam int IDX_W = 4;
  localparam int IDX_LSB = 2;
  localparam int SYNC_STAGES = 3;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION = 4'h0;
  localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION_SET = 4'h1;
  localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION_CLEAR = 4'h2;
  localparam logic [IDX_W-1:0] IDX_PIN_DIRECTION_TOGGLE = 4'h3;
  localparam logic [IDX_W-1:0] IDX_PIN_DRIVE_LEVEL = 4'h4;
  localparam logic [IDX_W-1:0] IDX_PIN_DRIVE_LEVEL_SET = 4'h5;
  localparam logic [IDX_W-1:0] IDX_PIN_DRIVE_LEVEL_CLEAR = 4'h6;
  localparam logic [IDX_W-1:0] IDX_NONE = 4'hf;

  localparam logic [PIN_W-1:0] PIN_RESET = 8'h00;
  localparam logic [DATA_W-PIN_W-1:0] UPPER_ZERO = 24'h000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OP_WRITE,
    OP_SET,
    OP_CLEAR,
    OP_TOGGLE
  } strobe_op_t;

  // Word index of a byte address; IDX_NONE when beyond the map
  function automatic logic [IDX_W-1:0] reg_index(
    input logic [ADDR_W-1:0] addr
  );
    logic [IDX_W-1:0] idx;
    idx = addr[IDX_LSB +: IDX_W];
    if (addr[ADDR_W-1:IDX_LSB+IDX_W] != '0) begin
      return IDX_NONE;
    end
    if (idx > IDX_PIN_DRIVE_LEVEL_CLEAR) begin
      return IDX_NONE;
    end
    return idx;
  endfunction

  function automatic logic is_dir_group(input logic [IDX_W-1:0] idx);
    return idx <= IDX_PIN_DIRECTION_TOGGLE;
  endfunction

  function automatic logic is_level_group(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_PIN_DRIVE_LEVEL) &&
           (idx <= IDX_PIN_DRIVE_LEVEL_CLEAR);
  endfunction
endpackage

//--- core/reg_write_if.sv
`timescale 1ns/1ps
`default_nettype none
interface reg_write_if;
  import gpio_port_pkg::*;
  logic wr;
  strobe_op_t op;
  logic [PIN_W-1:0] data;
  logic [PIN_W-1:0] value;

  modport ctrl(output wr, output op, output data, input value);
  modport unit(input wr, input op, input data, output value);
endinterface
`default_nettype wire

//--- core/pin_reg_unit.sv
`timescale 1ns/1ps
`default_nettype none
module pin_reg_unit (
  input wire logic aclk,
  input wire logic aresetn,
  reg_write_if.unit bus
);
  import gpio_port_pkg::*;

  logic [PIN_W-1:0] value_q;
  logic [PIN_W-1:0] value_d;

  // Single-write bit updates, no read-modify-write needed
  always_comb begin
    value_d = value_q;
    if (bus.wr) begin
      unique case (bus.op)
        OP_WRITE: value_d = bus.data;
        OP_SET: value_d = value_q | bus.data;
        OP_CLEAR: value_d = value_q & ~bus.data;
        OP_TOGGLE: value_d = value_q ^ bus.data;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_q <= PIN_RESET;
    end else begin
      value_q <= value_d;
    end
  end

  assign bus.value = value_q;
endmodule
`default_nettype wire

//--- core/pin_input_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module pin_input_sampler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [gpio_port_pkg::PIN_W-1:0] pin_in,
  input wire logic [gpio_port_pkg::PIN_W-1:0] buffer_en,
  output logic [gpio_port_pkg::PIN_W-1:0] sampled
);
  import gpio_port_pkg::*;

  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic [PIN_W-1:0] sync3_q;
  logic [PIN_W-1:0] sampled_q;
  logic [PIN_W-1:0] take;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= PIN_RESET;
      sync2_q <= PIN_RESET;
      sync3_q <= PIN_RESET;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // buffer gated by its own enable and by sync2_q agreeing with sync3_q
  assign take = buffer_en & ~(sync2_q ^ sync3_q);

  // Disabled pins keep their last sample rather than reading zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sampled_q <= PIN_RESET;
    end else begin
      sampled_q <= (take & sync3_q) | (~take & sampled_q);
    end
  end

  assign sampled = sampled_q;

  // The enable seen one edge earlier decides whether the sample may move
  AST_IN_HOLD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((~$past(buffer_en) & ($past(sampled_q) ^ sampled_q)) == '0))
    else $error("sample changed on a disabled input buffer");
endmodule
`default_nettype wire

//--- core/pin_port_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pin_port_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [gpio_port_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [gpio_port_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [gpio_port_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gpio_port_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [gpio_port_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [gpio_port_pkg::PIN_W-1:0] pin_in,
  input wire logic [gpio_port_pkg::PIN_W-1:0] input_buffer_en,
  output logic [gpio_port_pkg::PIN_W-1:0] pin_in_sampled,
  output logic [gpio_port_pkg::PIN_W-1:0] pin_out,
  output logic [gpio_port_pkg::PIN_W-1:0] pin_oe
);
  import gpio_port_pkg::*;

  logic [ADDR_W-1:0] aw_addr_q;
  logic aw_full_q;
  logic [PIN_W-1:0] w_data_q;
  logic w_lane0_q;
  logic w_full_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic commit;
  logic ar_take;
  logic [IDX_W-1:0] w_idx;
  logic [IDX_W-1:0] r_idx;
  logic [PIN_W-1:0] dir_val;
  logic [PIN_W-1:0] level_val;
  logic [PIN_W-1:0] read_val;

  reg_write_if dir_if();
  reg_write_if level_if();

  // Protection bits carry no meaning for this port
  logic prot_unused;
  assign prot_unused = ^{s_axi_awprot, s_axi_arprot};

  // Write address and data are taken in either order, one write in flight
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign commit = aw_full_q && w_full_q && !bvalid_q;
  assign w_idx = reg_index(aw_addr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (commit) begin
      aw_full_q <= 1'b0;
    end
  end

  // Only byte lane 0 holds register bits; upper lanes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_data_q <= PIN_RESET;
      w_lane0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata[PIN_W-1:0];
      w_lane0_q <= s_axi_wstrb[0];
    end else if (commit) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (commit) begin
      bvalid_q <= 1'b1;
      bresp_q <= (w_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  assign dir_if.data = w_data_q;
  assign level_if.data = w_data_q;

  assign dir_if.wr = commit && w_lane0_q && is_dir_group(w_idx);
  always_comb begin
    unique case (w_idx)
      IDX_PIN_DIRECTION_SET: dir_if.op = OP_SET;
      IDX_PIN_DIRECTION_CLEAR: dir_if.op = OP_CLEAR;
      IDX_PIN_DIRECTION_TOGGLE: dir_if.op = OP_TOGGLE;
      default: dir_if.op = OP_WRITE;
    endcase
  end

  assign level_if.wr = commit && w_lane0_q && is_level_group(w_idx);
  always_comb begin
    unique case (w_idx)
      IDX_PIN_DRIVE_LEVEL_SET: level_if.op = OP_SET;
      IDX_PIN_DRIVE_LEVEL_CLEAR: level_if.op = OP_CLEAR;
      default: level_if.op = OP_WRITE;
    endcase
  end

  pin_reg_unit u_direction (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(dir_if.unit)
  );

  pin_reg_unit u_drive_level (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(level_if.unit)
  );

  assign dir_val = dir_if.value;
  assign level_val = level_if.value;

  // Read channel: one read in flight, data registered at the handshake
  assign s_axi_arready = !rvalid_q;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign r_idx = reg_index(s_axi_araddr);

  always_comb begin
    read_val = PIN_RESET;
    if (is_dir_group(r_idx)) begin
      read_val = dir_val;
    end else if (is_level_group(r_idx)) begin
      read_val = level_val;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {UPPER_ZERO, read_val};
      rresp_q <= (r_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  assign pin_oe = dir_val;
  assign pin_out = level_val & dir_val;

  pin_input_sampler u_sampler (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pin_in),
    .buffer_en(input_buffer_en),
    .sampled(pin_in_sampled)
  );

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_DIR_SET: assert property (
    dir_if.wr && dir_if.op == OP_SET
    |=> dir_val == ($past(dir_val) | $past(w_data_q)))
    else $error("direction set strobe gave wrong value");

  AST_DIR_CLEAR: assert property (
    dir_if.wr && dir_if.op == OP_CLEAR
    |=> dir_val == ($past(dir_val) & ~$past(w_data_q)))
    else $error("direction clear strobe gave wrong value");

  AST_DIR_TOGGLE: assert property (
    dir_if.wr && dir_if.op == OP_TOGGLE
    |=> dir_val == ($past(dir_val) ^ $past(w_data_q)))
    else $error("direction toggle strobe gave wrong value");

  AST_LEVEL_SET: assert property (
    level_if.wr && level_if.op == OP_SET
    |=> level_val == ($past(level_val) | $past(w_data_q)))
    else $error("level set strobe gave wrong value");

  AST_LEVEL_CLEAR: assert property (
    level_if.wr && level_if.op == OP_CLEAR
    |=> level_val == ($past(level_val) & ~$past(w_data_q)))
    else $error("level clear strobe gave wrong value");

  AST_DIR_QUIET: assert property (
    !dir_if.wr |=> $stable(dir_val))
    else $error("direction changed without a write");

  AST_LEVEL_QUIET: assert property (
    !level_if.wr |=> $stable(level_val))
    else $error("level changed without a write");

  AST_DRIVER: assert property (
    dir_if.wr && dir_if.op == OP_WRITE
    |=> pin_oe == $past(w_data_q))
    else $error("driver enable does not follow direction write");

  AST_GATED_LEVEL: assert property (
    (pin_out & ~pin_oe) == '0)
    else $error("level reached a pin whose driver is off");

  AST_LEVEL_PIN: assert property (
    $rose(level_if.wr) && level_if.op == OP_SET && (w_data_q & dir_val) != '0
    |=> (pin_out & $past(w_data_q) & dir_val) == ($past(w_data_q) & dir_val))
    else $error("driven pin did not go high after set");

  AST_READ_DIR: assert property (
    ar_take && is_dir_group(r_idx)
    |=> s_axi_rvalid && s_axi_rdata == {UPPER_ZERO, $past(dir_val)})
    else $error("direction strobe read wrong data");

  AST_READ_LEVEL: assert property (
    ar_take && is_level_group(r_idx)
    |=> s_axi_rvalid && s_axi_rdata == {UPPER_ZERO, $past(level_val)})
    else $error("level strobe read wrong data");

  AST_WRITE_RESP: assert property (
    commit |=> s_axi_bvalid && !commit)
    else $error("write response missing after commit");

  AST_RESP_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");

  AST_AW_ONE: assert property (
    s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready)
    else $error("second write address taken while one is held");

  AST_W_ONE: assert property (
    s_axi_wvalid && s_axi_wready
    |=> !s_axi_wready)
    else $error("second write data taken while one is held");

  AST_READ_ONE: assert property (
    ar_take
    |=> !s_axi_arready)
    else $error("read address taken while a read is open");

  AST_READ_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before rready");

  AST_RESP_STABLE: assert property (
    s_axi_bvalid && !s_axi_bready
    |=> $stable(s_axi_bresp))
    else $error("write response code changed before bready");

  AST_RESP_DONE: assert property (
    s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid)
    else $error("write response stayed after bready");

  AST_READ_DONE: assert property (
    s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid)
    else $error("read answer stayed after rready");

  AST_READ_UNMAPPED: assert property (
    ar_take && r_idx == IDX_NONE
    |=> s_axi_rdata == '0 && s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read gave data or no error");

  AST_WRITE_UNMAPPED: assert property (
    commit && w_idx == IDX_NONE
    |=> s_axi_bresp == RESP_SLVERR &&
        $stable(dir_val) && $stable(level_val))
    else $error("unmapped write changed state or gave no error");

  AST_RESP_OKAY: assert property (
    commit && w_idx != IDX_NONE
    |=> s_axi_bresp == RESP_OKAY)
    else $error("mapped write gave an error response");

  AST_LANE_OFF: assert property (
    commit && !w_lane0_q
    |=> $stable(dir_val) && $stable(level_val))
    else $error("write with low lane off changed a register");

  AST_LEVEL_WRITE: assert property (
    level_if.wr && level_if.op == OP_WRITE
    |=> level_val == $past(w_data_q))
    else $error("level write did not land");

  AST_PIN_LOW: assert property (
    level_if.wr && level_if.op == OP_CLEAR
    |=> (pin_out & $past(w_data_q)) == '0)
    else $error("cleared level still drives a pin high");

  AST_DIR_OFF_PIN: assert property (
    dir_if.wr && dir_if.op == OP_CLEAR
    |=> (pin_oe & $past(w_data_q)) == '0)
    else $error("cleared direction left a driver on");

  AST_DIR_ON_PIN: assert property (
    dir_if.wr && dir_if.op == OP_SET
    |=> (pin_oe & $past(w_data_q)) == $past(w_data_q))
    else $error("set direction did not turn a driver on");

  COV_DIR_TOGGLE: cover property (
    dir_if.wr && dir_if.op == OP_TOGGLE && w_data_q != '0);
  COV_LEVEL_SET_DRIVEN: cover property (
    level_if.wr && level_if.op == OP_SET ##1 pin_out != '0);
  COV_READ_STROBE: cover property (
    ar_take && r_idx == IDX_PIN_DIRECTION_CLEAR);
  COV_DATA_FIRST: cover property (
    w_full_q && !aw_full_q ##1 commit);
  COV_READ_UNMAPPED: cover property (
    ar_take && r_idx == IDX_NONE);
endmodule
`default_nettype wire

//--- verification/port_direction_output_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module port_direction_output_regs_bench;
  import gpio_port_pkg::*;
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr, pin_in, buf_en, sampled, pin_out, pin_oe;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] dir_m, lvl_m;
  int n_mismatch, checked, seed;

  pin_port_regs pin_port_regs_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .input_buffer_en(buf_en),
    .pin_in_sampled(sampled), .pin_out(pin_out), .pin_oe(pin_oe)
  );

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Next target value for op 0 write, 1 set, 2 clear, 3 toggle
  function automatic logic [7:0] nxt(input logic [7:0] cur,
                                     input logic [1:0] op,
                                     input logic [7:0] d);
    case (op)
      2'h0: return d;
      2'h1: return cur | d;
      2'h2: return cur & ~d;
      default: return cur ^ d;
    endcase
  endfunction

  function automatic logic [31:0] rd_exp(input logic [2:0] idx);
    if (idx < 3'h4) return {24'h000000, dir_m};
    if (idx < 3'h7) return {24'h000000, lvl_m};
    return 32'h00000000;
  endfunction

  function automatic logic [1:0] rsp_exp(input logic [2:0] idx);
    return (idx == 3'h7) ? RESP_SLVERR : RESP_OKAY;
  endfunction

  task automatic axi_write(input logic [2:0] idx, input logic [31:0] d,
                           input logic [3:0] s);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= {3'h0, idx, 2'h0};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid === 1'b1 && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(rsp_exp(idx)));
    // Model follows a mapped write whose low byte lane is enabled
    if (idx != 3'h7 && s[0]) begin
      if (idx < 3'h4) dir_m = nxt(dir_m, idx[1:0], d[7:0]);
      else lvl_m = nxt(lvl_m, idx[1:0] - 2'h0, d[7:0]);
    end
  endtask

  task automatic axi_read(input logic [2:0] idx);
    @(posedge aclk);
    araddr <= {3'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, rd_exp(idx));
    chk(32'(rresp), 32'(rsp_exp(idx)));
  endtask

  task automatic chk_pins();
    chk(32'(pin_oe), 32'(dir_m));
    chk(32'(pin_out), 32'(dir_m & lvl_m));
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    dir_m = 8'h00;
    lvl_m = 8'h00;
  endtask

  // Corner cases: full set, partial toggle, zero strobes, lane disabled
  localparam logic [2:0] C_IDX [10] = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h2,
                                        3'h1, 3'h3, 3'h0, 3'h4, 3'h6};
  localparam logic [7:0] C_DAT [10] = '{8'hff, 8'h0f, 8'ha5, 8'h00, 8'h00,
                                        8'h00, 8'hf0, 8'h3c, 8'hff, 8'h81};

  logic [31:0] r;
  initial begin
    seed = 89;
    n_mismatch = 0;
    checked = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    pin_in = 8'h00;
    buf_en = 8'h00;
    do_reset();
    for (int i = 0; i < 7; i++) axi_read(i[2:0]);
    chk_pins();
    for (int i = 0; i < 10; i++) begin
      axi_write(C_IDX[i], {24'hdead00, C_DAT[i]}, 4'hf);
      chk_pins();
      axi_read(C_IDX[i]);
    end
    axi_write(3'h1, 32'h000000ff, 4'he);
    axi_write(3'h7, 32'h000000ff, 4'hf);
    chk_pins();
    for (int i = 0; i < 250; i++) begin
      r = $random(seed);
      axi_write(r[2:0], $random(seed), {r[7:5], r[8] | r[9]});
      chk_pins();
      axi_read(r[12:10]);
    end
    for (int k = 0; k < 2; k++) begin
      axi_write(3'h0, k ? 32'h000000ff : 32'h00000000, 4'hf);
      r = $random(seed);
      @(posedge aclk);
      buf_en <= 8'hff;
      pin_in <= r[7:0];
      repeat (6) @(posedge aclk);
      chk(32'(sampled), 32'(r[7:0]));
      buf_en <= 8'h00;
      pin_in <= ~r[7:0];
      repeat (6) @(posedge aclk);
      chk(32'(sampled), 32'(r[7:0]));
    end
    do_reset();
    @(posedge aclk);
    chk_pins();
    axi_read(3'h0);
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
